// [logic/clock_config_map.vh]
// register map, field positions and codes of the clock configuration block
`ifndef CLOCK_CONFIG_MAP_VH
`define CLOCK_CONFIG_MAP_VH
`define CFG_ONE_ADDR 4'h4
`define CFG_ONE_RESET 32'h00000000
`define CFG_ONE_WMASK 32'h0F3F07F3
`define SRC_RC 2'h0
`define SRC_EXT 2'h1
`define SRC_PLL 2'h2
`define SRC_RSVD 2'h3
`define SW_LO 1
`define SW_HI 0
`define STS_LO 3
`define STS_HI 2
`define AHB_HI 7
`define AHB_LO 4
`define APB_HI 10
`define APB_LO 8
`define PLLSRC_BIT 16
`define PREDIV_BIT 17
`define MUL_HI 21
`define MUL_LO 18
`define MCO_HI 27
`define MCO_LO 24
`define MCO_NONE 4'h0
`define MCO_I14 4'h1
`define MCO_LSI 4'h2
`define MCO_LSE 4'h3
`define MCO_SYS 4'h4
`define MCO_RC 4'h5
`define MCO_PLL 4'h7
`define SW_WAIT 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [logic/clock_config_register.v]
// clock configuration register with axi4-lite slave and clock steering
`timescale 1ns/1ps
// What this block does
// - word/half/byte access, waits during clock switch
// - select bits pick system clock source
// - force internal rc on wake or failure
// - status bits show the active source
// - main bus prescaler from bits 7:4
// - peripheral bus prescaler from bits 10:8
// - bit 16 picks pll input source
// - bit 17 is external oscillator prediv
// - pll multiplier is field plus two, max 16
// - bits 27:24 pick clock output source
// - writable fields change only by software, except select bits forced to rc
// - pll enable held while selected, cleared sleeping
module clock_config_register (
  input wire mclk_i,
  input wire rst_i,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire wake_from_low_power_i,
  input wire enter_low_power_i,
  input wire ext_osc_fail_i,
  input wire clock_security_on_i,
  input wire pll_enable_req_i,
  input wire pll_enable_wr_i,
  output reg pll_enable_bit_o,
  output reg [1:0] sys_clk_switch_status_o,
  output reg [9:0] main_bus_div_o,
  output reg [4:0] peripheral_bus_div_o,
  output reg pll_input_select_o,
  output reg pll_ext_osc_prediv_o,
  output reg [4:0] pll_multiplier_o,
  output reg [3:0] clock_out_select_o
);
`include "clock_config_map.vh"
  reg [31:0] cfg_reg;
  reg [31:0] cfg_next;
  reg [31:0] aw_addr_reg;
  reg aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_have_reg;
  reg [31:0] ar_addr_reg;
  reg ar_have_reg;
  wire [1:0] active_src;
  wire switching;
  wire force_rc;
  wire ext_in_use;
  wire do_write;
  wire [31:0] status_word;

  // divide factor of main bus prescaler code
  function [9:0] ahb_div;
    input [3:0] code;
    begin
      if (!code[3])
        ahb_div = 10'h001;
      else if (!code[2])
        ahb_div = 10'h002 << code[1:0];
      else
        ahb_div = 10'h040 << code[1:0];
    end
  endfunction

  // divide factor of peripheral bus prescaler code
  function [4:0] apb_div;
    input [2:0] code;
    begin
      if (!code[2])
        apb_div = 5'h01;
      else
        apb_div = 5'h02 << code[1:0];
    end
  endfunction

  // pll multiplication factor
  function [4:0] pll_mul;
    input [3:0] code;
    begin
      if (code == 4'hF)
        pll_mul = 5'h10;
      else
        pll_mul = {1'b0, code} + 5'h02;
    end
  endfunction

  // byte-lane merge for narrow writes
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          lane_merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  clock_glitch_mux u_mux (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sel_i(cfg_reg[`SW_LO:`SW_HI]),
    .active_o(active_src),
    .switching_o(switching)
  );

  assign ext_in_use = (active_src == `SRC_EXT) ||
    (active_src == `SRC_PLL && cfg_reg[`PLLSRC_BIT]);
  assign force_rc = wake_from_low_power_i ||
    (ext_osc_fail_i && clock_security_on_i && ext_in_use);
  // writes wait out a clock switch
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid &&
    !switching;

  always @* begin
    cfg_next = cfg_reg;
    if (do_write && aw_addr_reg[3:2] == `CFG_ONE_ADDR >> 2 &&
        aw_addr_reg[31:4] == 28'h0000000)
      cfg_next = (lane_merge(cfg_reg, w_data_reg, w_strb_reg) &
        `CFG_ONE_WMASK);
    if (force_rc)
      cfg_next[`SW_LO:`SW_HI] = `SRC_RC;
    cfg_next[`STS_LO:`STS_HI] = 2'h0;
  end

  assign status_word = {cfg_reg[31:4], active_src, cfg_reg[1:0]};

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= `CFG_ONE_RESET;
      aw_addr_reg <= 32'h00000000;
      aw_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      w_have_reg <= 1'b0;
      ar_addr_reg <= 32'h00000000;
      ar_have_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      cfg_reg <= cfg_next;
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[31:2] == `CFG_ONE_ADDR >> 2) ?
          `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !ar_have_reg && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
        ar_have_reg <= 1'b1;
      if (s_axi_arvalid && s_axi_arready)
        ar_addr_reg <= s_axi_araddr;
      // reads also wait out a clock switch
      if (ar_have_reg && !s_axi_rvalid && !switching) begin
        ar_have_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (ar_addr_reg[31:2] == `CFG_ONE_ADDR >> 2) begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= `RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pll enable: software cannot clear it while pll selected or active; low power entry clears it
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      pll_enable_bit_o <= 1'b0;
    else if (enter_low_power_i)
      pll_enable_bit_o <= 1'b0;
    else if (pll_enable_wr_i) begin
      if (pll_enable_req_i)
        pll_enable_bit_o <= 1'b1;
      else if (cfg_reg[`SW_LO:`SW_HI] != `SRC_PLL &&
               active_src != `SRC_PLL)
        pll_enable_bit_o <= 1'b0;
    end
  end

  // decoded steering outputs
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_clk_switch_status_o <= `SRC_RC;
      main_bus_div_o <= 10'h001;
      peripheral_bus_div_o <= 5'h01;
      pll_input_select_o <= 1'b0;
      pll_ext_osc_prediv_o <= 1'b0;
      pll_multiplier_o <= 5'h02;
      clock_out_select_o <= `MCO_NONE;
    end else begin
      sys_clk_switch_status_o <= active_src;
      main_bus_div_o <= ahb_div(cfg_reg[`AHB_HI:`AHB_LO]);
      peripheral_bus_div_o <= apb_div(cfg_reg[`APB_HI:`APB_LO]);
      pll_input_select_o <= cfg_reg[`PLLSRC_BIT];
      pll_ext_osc_prediv_o <= cfg_reg[`PREDIV_BIT];
      pll_multiplier_o <= pll_mul(cfg_reg[`MUL_HI:`MUL_LO]);
      clock_out_select_o <= cfg_reg[`MCO_HI:`MCO_LO];
    end
  end
endmodule // clock_config_register

// [logic/clock_glitch_mux.v]
// glitch-free three-way clock source switch with take-over report
`timescale 1ns/1ps
module clock_glitch_mux (
  input wire mclk_i,
  input wire rst_i,
  input wire [1:0] sel_i,
  output reg [1:0] active_o,
  output reg switching_o
);
`include "clock_config_map.vh"
  reg [1:0] wait_reg;
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= `SRC_RC;
      wait_reg <= 2'h0;
      switching_o <= 1'b0;
    end else if (sel_i != active_o && sel_i != `SRC_RSVD) begin
      switching_o <= 1'b1;
      // old source gated off, then new one gated on
      if (wait_reg == `SW_WAIT - 2'h1) begin
        active_o <= sel_i;
        wait_reg <= 2'h0;
      end else begin
        wait_reg <= wait_reg + 2'h1;
      end
    end else begin
      switching_o <= 1'b0;
      wait_reg <= 2'h0;
    end
  end
endmodule // clock_glitch_mux

// [verif/clock_config_register_assertions.sv]
// checker for the clock configuration register ports
`timescale 1ns/1ps
module clock_config_register_checker (
  input wire mclk_i,
  input wire rst_i,
  input wire s_axi_awvalid,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire enter_low_power_i,
  input wire pll_enable_bit_o,
  input wire [1:0] sys_clk_switch_status_o,
  input wire [9:0] main_bus_div_o,
  input wire [4:0] peripheral_bus_div_o,
  input wire [4:0] pll_multiplier_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_status_legal: assert property (sys_clk_switch_status_o != 2'h3)
    else $error("status code 3");
  chk_write_answer: assert property (
    $rose(s_axi_awvalid) |-> ##[2:6] s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (
    $rose(s_axi_arvalid) |-> ##[2:6] s_axi_rvalid)
    else $error("read answer late");
  chk_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_ahb_div: assert property (
    $onehot(main_bus_div_o) && !main_bus_div_o[5])
    else $error("bad main bus divider");
  chk_apb_div: assert property ($onehot(peripheral_bus_div_o))
    else $error("bad peripheral divider");
  chk_mul_range: assert property (
    pll_multiplier_o inside {[5'd2:5'd16]})
    else $error("bad multiplier");
  chk_pll_sleep: assert property (
    enter_low_power_i |-> ##[1:2] !pll_enable_bit_o)
    else $error("pll enable kept in stop");
  cover property (s_axi_bvalid);
  cover property (sys_clk_switch_status_o == 2'h2);
  cover property (enter_low_power_i && pll_enable_bit_o);
endmodule // clock_config_register_checker
bind clock_config_register clock_config_register_checker u_chk (.*);

// [verif/tb_system_clock_config_register.sv]
// self-checking bench for the clock configuration register
`timescale 1ns/1ps
`include "clock_config_map.vh"
module tb_system_clock_config_register;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, clock_out_select_o;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0] s_axi_bresp, s_axi_rresp, sys_clk_switch_status_o;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, wake_from_low_power_i;
  logic enter_low_power_i, ext_osc_fail_i, clock_security_on_i;
  logic pll_enable_req_i, pll_enable_wr_i, pll_enable_bit_o;
  logic pll_input_select_o, pll_ext_osc_prediv_o;
  logic [9:0] main_bus_div_o;
  logic [4:0] peripheral_bus_div_o, pll_multiplier_o;
  logic [31:0] m = 32'h0;
  logic [31:0] seed = 32'h62CB;
  logic [1:0] st = 2'h0;
  int fail_count = 0;
  int total_checks = 0;
  int i;
  clock_config_register DUT (.*);
  always #50 mclk_i = ~mclk_i;
  task chk(input [31:0] s, input [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function logic [31:0] xs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task upd(input [31:0] d, input [3:0] s);
    for (int k = 0; k < 4; k++) begin
      if (s[k]) m[k*8 +: 8] = d[k*8 +: 8];
    end
    m = m & `CFG_ONE_WMASK;
    if (m[1:0] != `SRC_RSVD) st = m[1:0];
  endtask
  task wr(input [31:0] a, input [31:0] d, input [3:0] s);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, a == 4 ? `RESP_OKAY : `RESP_SLVERR);
    if (a == 4) upd(d, s);
  endtask
  task rd(input [31:0] a);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, a == 4 ? {m[31:4], st, m[1:0]} : 0);
    chk(s_axi_rresp, a == 4 ? `RESP_OKAY : `RESP_SLVERR);
  endtask
  task ver;
    int a, p, q;
    repeat (6) @(posedge mclk_i);
    a = m[7:4];
    p = m[10:8];
    q = m[21:18];
    chk(sys_clk_switch_status_o, st);
    chk(main_bus_div_o, a < 8 ? 1 : 1 << (a - 7 + (a > 11)));
    chk(peripheral_bus_div_o, p < 4 ? 1 : 1 << (p - 3));
    chk(pll_multiplier_o, q == 15 ? 16 : q + 2);
    chk({pll_ext_osc_prediv_o, pll_input_select_o}, m[17:16]);
    chk(clock_out_select_o, m[27:24]);
    rd(32'h4);
    $display("step done at %0t", $time);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, wake_from_low_power_i} = '0;
    {enter_low_power_i, ext_osc_fail_i, clock_security_on_i} = '0;
    {pll_enable_req_i, pll_enable_wr_i} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    ver;
    // pll stays disabled while its fields change;
    // pll output frequency is not modelled here
    for (i = 0; i < 8; i++) begin
      wr(32'h4, xs(), 4'hF);
      ver;
    end
    for (i = 0; i < 4; i++) begin
      wr(32'h4, xs(), 4'h1 << i);
      ver;
    end
    wr(32'h8, xs(), 4'hF);
    rd(32'h8);
    wr(32'h4, {m[31:2], `SRC_EXT}, 4'h1);
    ver;
    clock_security_on_i <= 1'b1;
    ext_osc_fail_i <= 1'b1;
    @(posedge mclk_i);
    ext_osc_fail_i <= 1'b0;
    m[1:0] = `SRC_RC;
    st = `SRC_RC;
    ver;
    pll_enable_req_i <= 1'b1;
    pll_enable_wr_i <= 1'b1;
    @(posedge mclk_i);
    pll_enable_wr_i <= 1'b0;
    wr(32'h4, {m[31:2], `SRC_PLL}, 4'h1);
    ver;
    pll_enable_req_i <= 1'b0;
    pll_enable_wr_i <= 1'b1;
    @(posedge mclk_i);
    pll_enable_wr_i <= 1'b0;
    @(posedge mclk_i);
    chk(pll_enable_bit_o, 1);
    wake_from_low_power_i <= 1'b1;
    @(posedge mclk_i);
    wake_from_low_power_i <= 1'b0;
    m[1:0] = `SRC_RC;
    st = `SRC_RC;
    ver;
    enter_low_power_i <= 1'b1;
    @(posedge mclk_i);
    enter_low_power_i <= 1'b0;
    @(posedge mclk_i);
    chk(pll_enable_bit_o, 0);
    close_out;
  end
  initial begin
    #2000000;
    fail_count++;
    close_out;
  end
endmodule // tb_system_clock_config_register
